/* File: hdl/iobx_defines.vh */
`ifndef IOBX_DEFINES_VH
`define IOBX_DEFINES_VH

// ==========================================
// Operation select codes
`define IOBX_OP_NONE        3'h0
`define IOBX_OP_INCR_SKIP   3'h1
`define IOBX_OP_JUMP        3'h2
`define IOBX_OP_OR_LIT      3'h3
`define IOBX_OP_INCR_FILE   3'h4
`define IOBX_OP_OR_FILE     3'h5

// ==========================================
// Widths and field positions
`define IOBX_DATA_W         8
`define IOBX_ADDR_W         7
`define IOBX_PC_W           13
`define IOBX_JUMP_LIT_W     11
`define IOBX_LATCH_HI_BIT   4
`define IOBX_LATCH_LO_BIT   3

// ==========================================
// Destination select, reset values and constants
`define IOBX_DEST_ACC       1'h0
`define IOBX_DEST_FILE      1'h1
`define IOBX_ACC_RST        8'h00
`define IOBX_PC_RST         13'h0000
`define IOBX_ONE            8'h01
`define IOBX_ZERO           8'h00

`endif

/* File: hdl/iobx_alu.v */
`timescale 1ns/100ps

// ==========================================
// Combinational datapath
module iobx_alu (
	input  wire [2:0] opSel,
	input  wire [7:0] accIn,
	input  wire [7:0] fileIn,
	input  wire [7:0] litIn,
	output reg  [7:0] result,
	output wire       resultZero
);
`include "iobx_defines.vh"

	always @* begin
		case (opSel)
			`IOBX_OP_INCR_SKIP,
			`IOBX_OP_INCR_FILE: result = fileIn + `IOBX_ONE; // RULE8
			`IOBX_OP_OR_LIT:    result = accIn | litIn;      // RULE5
			`IOBX_OP_OR_FILE:   result = accIn | fileIn;     // RULE7
			default:            result = `IOBX_ZERO;
		endcase
	end

	assign resultZero = (result == `IOBX_ZERO); // RULE8

endmodule // iobx_alu

/* File: hdl/iobx_exec.v */
// Functional notes
// RULE1 - Increment-skip adds one to file reg; d picks acc or file; no flags.
// RULE2 - Zero increment-skip result discards next instruction; a no-op runs.
// RULE3 - Jump loads literal into pc low 11 bits, latch bits 4:3 to top.
// RULE4 - Jump takes two cycles; second flushes the fetched next instruction.
// RULE5 - OR literal into accumulator, result kept there; zero flag updated.
// RULE6 - Increment file register, destination by d bit, zero flag updated.
// RULE7 - OR accumulator with file reg, destination by d bit, zero flag set.
// RULE8 - Zero flag set on zero 8-bit result; increment wraps FF to 00.
// RULE9 - Increment, both ORs, and nonzero increment-skip take one cycle.
`timescale 1ns/100ps

module iobx_exec (
	input  wire        mclk,
	input  wire        sys_rst,
	input  wire        instrValid,
	input  wire [2:0]  opSel,
	input  wire        destSel,
	input  wire [6:0]  fileAddr,
	input  wire [7:0]  fileData,
	input  wire [7:0]  literal8,
	input  wire [10:0] jumpLiteral,
	input  wire [7:0]  pcHighLatch,
	input  wire [12:0] pcNext,
	output reg  [7:0]  accOut,
	output reg         zeroFlag,
	output reg         fileWrEn,
	output reg  [6:0]  fileWrAddr,
	output reg  [7:0]  fileWrData,
	output reg  [12:0] pcOut,
	output wire        flushNext,
	output wire        busy
);
`include "iobx_defines.vh"

	// ==========================================
	// State machine
	localparam ST_RUN   = 1'b0;
	localparam ST_FLUSH = 1'b1;

	reg        state_ff;
	reg        nxt_state;
	reg  [7:0] acc_ff;
	reg  [7:0] nxt_acc;
	reg        zero_ff;
	reg        nxt_zero;
	reg  [12:0] pc_ff;
	reg  [12:0] nxt_pc;
	reg        wrEn_ff;
	reg        nxt_wrEn;
	reg  [6:0] wrAddr_ff;
	reg  [7:0] wrData_ff;
	reg  [7:0] nxt_wrData;

	wire [7:0] aluResult;
	wire       aluZero;
	wire       issue;

	// Instruction slot in flush state is consumed as a no-op
	assign issue     = instrValid && (state_ff == ST_RUN);
	assign flushNext = (state_ff == ST_FLUSH); // RULE2 RULE4
	assign busy      = flushNext;

	iobx_alu uAlu (
		.opSel      (opSel),
		.accIn      (acc_ff),
		.fileIn     (fileData),
		.litIn      (literal8),
		.result     (aluResult),
		.resultZero (aluZero)
	);

	// ==========================================
	// Next state
	always @* begin
		nxt_state  = ST_RUN;
		nxt_acc    = acc_ff;
		nxt_zero   = zero_ff;
		nxt_pc     = pcNext;
		nxt_wrEn   = 1'b0;
		nxt_wrData = wrData_ff;
		case (state_ff)
			ST_RUN: begin
				if (issue) begin
					case (opSel)
						`IOBX_OP_INCR_SKIP: begin
							// Flags untouched by design
							if (destSel == `IOBX_DEST_ACC)
								nxt_acc = aluResult; // RULE1
							else begin
								nxt_wrEn   = 1'b1; // RULE1
								nxt_wrData = aluResult;
							end
							if (aluZero)
								nxt_state = ST_FLUSH; // RULE2
						end
						`IOBX_OP_JUMP: begin
							nxt_pc = {pcHighLatch[`IOBX_LATCH_HI_BIT:
								`IOBX_LATCH_LO_BIT], jumpLiteral}; // RULE3
							nxt_state = ST_FLUSH; // RULE4
						end
						`IOBX_OP_OR_LIT: begin
							nxt_acc  = aluResult; // RULE5 RULE9
							nxt_zero = aluZero;   // RULE8
						end
						`IOBX_OP_INCR_FILE,
						`IOBX_OP_OR_FILE: begin
							nxt_zero = aluZero; // RULE6 RULE7 RULE8 RULE9
							if (destSel == `IOBX_DEST_ACC)
								nxt_acc = aluResult;
							else begin
								nxt_wrEn   = 1'b1;
								nxt_wrData = aluResult;
							end
						end
						default: nxt_state = ST_RUN;
					endcase
				end
			end
			// pc loads pcNext: fetched instruction is dropped, a no-op runs
			ST_FLUSH: nxt_pc = pcNext; // RULE2 RULE4
			default:  nxt_state = ST_RUN;
		endcase
	end

	// ==========================================
	// Registers
	always @(posedge mclk) begin
		if (sys_rst) begin
			state_ff  <= ST_RUN;
			acc_ff    <= `IOBX_ACC_RST;
			zero_ff   <= 1'b0;
			pc_ff     <= `IOBX_PC_RST;
			wrEn_ff   <= 1'b0;
			wrAddr_ff <= 7'h00;
			wrData_ff <= `IOBX_ZERO;
		end else begin
			state_ff  <= nxt_state;
			acc_ff    <= nxt_acc;
			zero_ff   <= nxt_zero;
			pc_ff     <= nxt_pc;
			wrEn_ff   <= nxt_wrEn;
			wrAddr_ff <= fileAddr;
			wrData_ff <= nxt_wrData;
		end
	end

	always @* begin
		accOut     = acc_ff;
		zeroFlag   = zero_ff;
		fileWrEn   = wrEn_ff;
		fileWrAddr = wrAddr_ff;
		fileWrData = wrData_ff;
		pcOut      = pc_ff;
	end

endmodule // iobx_exec

/* File: testbench/iobx_chk.sv */
`timescale 1ns/100ps
module iobx_chk (
	input wire mclk, sys_rst, instrValid, destSel,
	input wire zeroFlag, fileWrEn, flushNext,
	input wire [2:0] opSel,
	input wire [7:0] fileData, literal8, pcHighLatch, accOut, fileWrData,
	input wire [10:0] jumpLiteral,
	input wire [12:0] pcOut
);
	// ====
	// Checks
	default clocking @(posedge mclk); endclocking
	default disable iff (sys_rst);
	wire t = instrValid && !flushNext;
	wire [1:0] hi = pcHighLatch[4:3];
	wire [7:0] inc = fileData + 8'h01;
	wire [7:0] orf = accOut | fileData;
	wire [7:0] orl = accOut | literal8;
	wire z = accOut == 8'h00;
	AST_SKZ: assert property (t && opSel == 3'h1 && !inc
		|=> flushNext && $stable(zeroFlag)) else $error("skip");
	AST_SKN: assert property (t && opSel == 3'h1 && inc
		|=> !flushNext && $stable(zeroFlag)) else $error("noskip");
	AST_SKW: assert property (t && opSel == 3'h1 && destSel
		|=> fileWrEn && fileWrData == $past(inc)) else $error("skipwr");
	AST_INC: assert property (t && opSel == 3'h4 && !destSel
		|=> accOut == $past(inc) && zeroFlag == z) else $error("inc");
	AST_JMP: assert property (t && opSel == 3'h2
		|=> flushNext && pcOut == {$past(hi), $past(jumpLiteral)})
		else $error("jump");
	AST_ORL: assert property (t && opSel == 3'h3
		|=> accOut == $past(orl) && zeroFlag == z) else $error("orl");
	AST_ORF: assert property (t && opSel == 3'h5 && destSel
		|=> fileWrEn && fileWrData == $past(orf)) else $error("orf");
	AST_FL: assert property (flushNext |=> !flushNext
		&& !fileWrEn && $stable(accOut)) else $error("flush");
	cover property (t && opSel == 3'h1 && !inc);
	cover property (t && opSel == 3'h2);
	cover property (flushNext && instrValid);
endmodule // iobx_chk
bind iobx_exec iobx_chk chk_u (.*);

/* File: testbench/testbench.sv */
`timescale 1ns/100ps
module testbench;
	reg mclk = 0, sys_rst = 1, instrValid = 0, destSel = 0;
	reg [2:0] opSel = 3'h0;
	reg [6:0] fileAddr = 7'h7F;
	reg [7:0] fileData = 8'h00, literal8 = 8'h00, pcHighLatch = 8'h18;
	reg [10:0] jumpLiteral = 11'h7FF;
	reg [12:0] pcNext = 13'h0123;
	wire [7:0] accOut, fileWrData;
	wire [6:0] fileWrAddr;
	wire [12:0] pcOut;
	wire zeroFlag, fileWrEn, flushNext, busy;
	integer err_count = 0, comparisons = 0;
	iobx_exec dut_u (
		.mclk        (mclk),
		.sys_rst     (sys_rst),
		.instrValid  (instrValid),
		.opSel       (opSel),
		.destSel     (destSel),
		.fileAddr    (fileAddr),
		.fileData    (fileData),
		.literal8    (literal8),
		.jumpLiteral (jumpLiteral),
		.pcHighLatch (pcHighLatch),
		.pcNext      (pcNext),
		.accOut      (accOut),
		.zeroFlag    (zeroFlag),
		.fileWrEn    (fileWrEn),
		.fileWrAddr  (fileWrAddr),
		.fileWrData  (fileWrData),
		.pcOut       (pcOut),
		.flushNext   (flushNext),
		.busy        (busy)
	);
	always #2.5 mclk = ~mclk;
	// ====
	// Tasks
	task cmp(input [15:0] n, input [12:0] e, s);
		comparisons = comparisons + 1;
		if (s !== e) begin
			err_count = err_count + 1;
			$display("mismatch %s exp %h got %h", n, e, s);
		end
	endtask
	// Lowers valid on the taking edge so nothing is taken twice
	task ex(input [2:0] o, input d, input [7:0] f, l);
		@(posedge mclk);
		opSel <= o;
		destSel <= d;
		fileData <= f;
		literal8 <= l;
		instrValid <= 1'h1;
		@(posedge mclk);
		instrValid <= 1'h0;
		#1;
	endtask
	task give_verdict;
		$display("err %0d cmp %0d", err_count, comparisons);
		if (err_count == 0 && comparisons > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	task s_alu;
		ex(3'h3, 1'h0, 8'h00, 8'h00);
		cmp("z", 13'h1, zeroFlag);
		ex(3'h4, 1'h0, 8'hFF, 8'h00);
		cmp("ia", 13'h100, {zeroFlag, accOut});
		ex(3'h4, 1'h1, 8'h7F, 8'h00);
		cmp("iw", 13'h180, {fileWrEn, fileWrData});
		cmp("wa", 13'h07F, fileWrAddr);
		cmp("pn", 13'h0123, pcOut);
		ex(3'h5, 1'h0, 8'h81, 8'h00);
		cmp("of", 13'h081, {zeroFlag, accOut});
		ex(3'h5, 1'h1, 8'h24, 8'h00);
		cmp("ow", 13'h1A5, {fileWrEn, fileWrData});
	endtask
	task s_skip;
		ex(3'h1, 1'h1, 8'hFF, 8'h00);
		cmp("sk", 13'h300, {flushNext, fileWrEn, fileWrData});
		cmp("bz", 13'h1, busy);
		ex(3'h1, 1'h0, 8'h10, 8'h00);
		cmp("sn", 13'h011, {flushNext, fileWrEn, accOut});
	endtask
	task s_jump;
		ex(3'h2, 1'h0, 8'h00, 8'h00);
		cmp("j", 13'h1FFF, pcOut);
		cmp("jf", 13'h1, flushNext);
		@(posedge mclk);
		pcHighLatch <= 8'h08;
		jumpLiteral <= 11'h2A5;
		#1;
		ex(3'h2, 1'h0, 8'h00, 8'h00);
		cmp("j2", 13'h0AA5, pcOut);
		ex(3'h0, 1'h0, 8'h00, 8'h00);
		cmp("jn", 13'h0123, pcOut);
	endtask
	task s_ref;
		@(posedge mclk);
		opSel <= 3'h1;
		fileData <= 8'hFF;
		destSel <= 1'h0;
		instrValid <= 1'h1;
		@(posedge mclk);
		opSel <= 3'h3;
		literal8 <= 8'h5A;
		@(posedge mclk);
		instrValid <= 1'h0;
		#1;
		cmp("rf", 13'h0, accOut);
	endtask
	initial begin
		repeat (12) @(posedge mclk);
		sys_rst <= 1'h0;
		s_alu;
		s_skip;
		s_jump;
		s_ref;
		give_verdict;
	end
	initial begin
		#2000;
		err_count = err_count + 1;
		give_verdict;
	end
endmodule // testbench
